// file: design/bank_addr_defines.svh
// constants for the banked data memory addressing block
`ifndef BANK_ADDR_DEFINES_SVH
`define BANK_ADDR_DEFINES_SVH

`define ADDR_W          12
`define BANK_W          4
`define OFFS_W          8
`define DATA_W          8
`define NUM_BANKS       16
`define BANK_BYTES      256
`define BANK_PTR_RESET  4'h0
`define BANK_PTR_SFR    12'hfe0
`define PCL_ADDR        12'hff9
`define PCL_OFFS        8'hf9
`define SFR_BANK        4'hf
`define WIN_SPLIT       8'h80
`define ZERO_BYTE       8'h00

`endif

// file: design/bank_addr_pkg.sv
// types shared by the banked data memory addressing block
package bank_addr_pkg;
    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_BANK  = 2'b01,
        OP_FULL  = 2'b10,
        OP_LOADB = 2'b11
    } op_type;
endpackage

// file: design/data_ram_bank.sv
// one bank of general purpose byte storage
`timescale 1ns/1ps
module data_ram_bank #(
    parameter int DEPTH = 256,
    parameter int AW    = 8,
    parameter int DW    = 8
) (
    // clock
    input  wire logic          core_clk,
    // port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    logic [DW-1:0] mem [DEPTH];

    // no write-first: a banked write also reads that byte in the same cycle, and opRd_r takes the old value
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_comb begin
        rdData = mem[rdAddr];
    end
endmodule

// file: design/banked_data_memory_addressing.sv
// address formation and storage for the banked data memory
`timescale 1ns/1ps
`include "bank_addr_defines.svh"
module banked_data_memory_addressing #(
    parameter int             NUM_BANKS = `NUM_BANKS,
    parameter logic [`BANK_W-1:0] IMPL_BANKS_LAST = 4'hf,
    parameter logic [`OFFS_W-1:0] WIN_SPLIT = `WIN_SPLIT
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // execution unit request
    input  bank_addr_pkg::op_type     opKind,
    input  wire logic                 opWrite,
    input  wire logic                 accessSel,
    input  wire logic [`OFFS_W-1:0]   opOffset,
    input  wire logic [`ADDR_W-1:0]   srcAddr,
    input  wire logic [`ADDR_W-1:0]   dstAddr,
    input  wire logic [`DATA_W-1:0]   opWrData,
    output logic      [`DATA_W-1:0]   opRdData,
    output logic                      flagUpdate,
    // program counter low byte
    input  wire logic [`DATA_W-1:0]   pcLowIn,
    output logic                      pcLowWe,
    output logic      [`DATA_W-1:0]   pcLowData,
    // register port
    input  wire logic [`ADDR_W-1:0]   regAddr,
    input  wire logic [`DATA_W-1:0]   regWrData,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [`DATA_W-1:0]   regRdData,
    // state
    output logic      [`BANK_W-1:0]   bankPointer
);
    import bank_addr_pkg::*;

    // ----------------------------------------------------------------
    // bank pointer
    // ----------------------------------------------------------------
    logic [`BANK_W-1:0] bankPtr_r;
    logic               bpWriteOp;
    logic               bpWriteReg;
    logic [`DATA_W-1:0] wrDataSel;

    // a full move into the pointer carries the source byte, so take the steered write data
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bankPtr_r <= `BANK_PTR_RESET;
        end else if (opKind == OP_LOADB) begin
            bankPtr_r <= opOffset[`BANK_W-1:0];
        end else if (bpWriteOp || bpWriteReg) begin
            bankPtr_r <= wrDataSel[`BANK_W-1:0];
        end
    end

    assign bankPointer = bankPtr_r;

    // ----------------------------------------------------------------
    // address formation
    // ----------------------------------------------------------------
    logic [`ADDR_W-1:0] bankedAddr;
    logic [`ADDR_W-1:0] opAddr;
    logic [`ADDR_W-1:0] rdAddrSel;
    logic [`ADDR_W-1:0] wrAddrSel;

    always_comb begin
        // low half of window is bank 0, upper half is the sfr bank
        if (!accessSel) begin
            if (opOffset < WIN_SPLIT) begin
                bankedAddr = {{`BANK_W{1'b0}}, opOffset};
            end else begin
                bankedAddr = {`SFR_BANK, opOffset};
            end
        end else begin
            bankedAddr = {bankPtr_r, opOffset};
        end
    end

    always_comb begin
        case (opKind)
            OP_FULL: begin
                rdAddrSel = srcAddr;
                wrAddrSel = dstAddr;
            end
            OP_BANK: begin
                rdAddrSel = bankedAddr;
                wrAddrSel = bankedAddr;
            end
            default: begin
                rdAddrSel = regAddr;
                wrAddrSel = regAddr;
            end
        endcase
    end
    assign opAddr = wrAddrSel;

    // ----------------------------------------------------------------
    // write steering
    // ----------------------------------------------------------------
    logic               doWrite;
    logic [`DATA_W-1:0] fullMoveData;
    logic               wrImpl;
    logic               isPcl;
    logic               isBsr;

    // a continuous assign would not wake up when the bank read data inside the function moves
    always_comb begin
        fullMoveData = ramRead(srcAddr);
    end
    assign doWrite   = ((opKind == OP_BANK) && opWrite) || (opKind == OP_FULL) ||
                       ((opKind == OP_NONE) && regWrite);
    assign wrDataSel = (opKind == OP_FULL) ? fullMoveData :
                       (opKind == OP_BANK) ? opWrData : regWrData;
    assign wrImpl    = (opAddr[`ADDR_W-1:`OFFS_W] <= IMPL_BANKS_LAST);
    assign isPcl     = (opAddr == `PCL_ADDR);
    assign isBsr     = (opAddr == `BANK_PTR_SFR);
    assign bpWriteOp  = doWrite && isBsr && (opKind != OP_NONE);
    assign bpWriteReg = doWrite && isBsr && (opKind == OP_NONE);

    // ----------------------------------------------------------------
    // storage: sixteen banks of 256 bytes
    // ----------------------------------------------------------------
    logic [`DATA_W-1:0] bankRd [NUM_BANKS];
    logic [`OFFS_W-1:0] rdOffs;

    assign rdOffs = rdAddrSel[`OFFS_W-1:0];

    generate
        for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
            data_ram_bank #(
                .DEPTH (`BANK_BYTES),
                .AW    (`OFFS_W),
                .DW    (`DATA_W)
            ) u_bank (
                .core_clk (core_clk),
                .wrEn     (doWrite && wrImpl && !isPcl && !isBsr &&
                           (opAddr[`ADDR_W-1:`OFFS_W] == `BANK_W'(b))),
                .wrAddr   (opAddr[`OFFS_W-1:0]),
                .wrData   (wrDataSel),
                .rdAddr   (rdOffs),
                .rdData   (bankRd[b])
            );
        end
    endgenerate

    function automatic logic [`DATA_W-1:0] ramRead(input logic [`ADDR_W-1:0] a);
        logic [`BANK_W-1:0] bk;
        bk = a[`ADDR_W-1:`OFFS_W];
        // pointer and pc low are real registers, so they read back even on a part without bank f
        if (a == `BANK_PTR_SFR) begin
            ramRead = {{(`DATA_W-`BANK_W){1'b0}}, bankPtr_r};
        end else if (a == `PCL_ADDR) begin
            ramRead = pcLowIn;
        end else if (bk > IMPL_BANKS_LAST) begin
            ramRead = `ZERO_BYTE;
        end else begin
            ramRead = bankRd[bk];
        end
    endfunction

    // ----------------------------------------------------------------
    // read data and side effects
    // ----------------------------------------------------------------
    logic [`DATA_W-1:0] opRd_r;
    logic [`DATA_W-1:0] regRd_r;
    logic               flag_r;
    logic               pcWe_r;
    logic [`DATA_W-1:0] pcData_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            opRd_r <= `ZERO_BYTE;
        end else if (opKind == OP_BANK || opKind == OP_FULL) begin
            opRd_r <= ramRead(rdAddrSel);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            regRd_r <= `ZERO_BYTE;
        end else if (regRead) begin
            regRd_r <= ramRead(regAddr);
        end else begin
            regRd_r <= `ZERO_BYTE;
        end
    end

    // flags follow every banked access, implemented or not
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= (opKind == OP_BANK) || (opKind == OP_FULL);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pcWe_r   <= 1'b0;
            pcData_r <= `ZERO_BYTE;
        end else begin
            pcWe_r   <= doWrite && isPcl;
            pcData_r <= wrDataSel;
        end
    end

    assign opRdData   = opRd_r;
    assign regRdData  = regRd_r;
    assign flagUpdate = flag_r;
    assign pcLowWe    = pcWe_r;
    assign pcLowData  = pcData_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_loadb_sets_ptr: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_LOADB |=> bankPtr_r == $past(opOffset[`BANK_W-1:0]))
        else $error("bank pointer not loaded by load bank");

    a_full_ignores_ptr: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_FULL |-> wrAddrSel == dstAddr && rdAddrSel == srcAddr)
        else $error("full move used bank pointer");

    a_banked_upper_bits: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK && accessSel |-> bankedAddr[`ADDR_W-1:`OFFS_W] == bankPtr_r)
        else $error("banked address upper bits wrong");

    a_window_no_ptr: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK && !accessSel && opOffset < WIN_SPLIT |-> bankedAddr[`ADDR_W-1:`OFFS_W] == 4'h0)
        else $error("window low half not in bank zero");

    a_offset_low_bits: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK |-> bankedAddr[`OFFS_W-1:0] == opOffset)
        else $error("offset not kept in low bits");

    a_ptr_readback: assert property (@(posedge core_clk) disable iff (srst)
        regRead && regAddr == `BANK_PTR_SFR |=> regRdData[`DATA_W-1:`BANK_W] == 4'h0
            && regRdData[`BANK_W-1:0] == $past(bankPtr_r))
        else $error("bank pointer upper nibble not zero");

    a_pc_write: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK && accessSel && opWrite && bankPtr_r == `SFR_BANK && opOffset == `PCL_OFFS
            |=> pcLowWe && pcLowData == $past(opWrData))
        else $error("pc low write missed");

    a_flags_follow: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK |=> flagUpdate)
        else $error("flags not updated");

    a_window_high_sfr: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK && !accessSel && opOffset >= WIN_SPLIT |-> bankedAddr[`ADDR_W-1:`OFFS_W] == `SFR_BANK)
        else $error("window upper half not in sfr bank");

    a_flags_full: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_FULL |=> flagUpdate)
        else $error("flags not updated by full move");

    a_flags_idle: assert property (@(posedge core_clk) disable iff (srst)
        opKind != OP_BANK && opKind != OP_FULL |=> !flagUpdate)
        else $error("flags pulsed without an access");

    a_unimpl_op_zero: assert property (@(posedge core_clk) disable iff (srst)
        (opKind == OP_BANK || opKind == OP_FULL) && rdAddrSel[`ADDR_W-1:`OFFS_W] > IMPL_BANKS_LAST
            && rdAddrSel != `BANK_PTR_SFR && rdAddrSel != `PCL_ADDR |=> opRdData == `ZERO_BYTE)
        else $error("unimplemented bank did not read zero");

    a_unimpl_reg_zero: assert property (@(posedge core_clk) disable iff (srst)
        regRead && regAddr[`ADDR_W-1:`OFFS_W] > IMPL_BANKS_LAST
            && regAddr != `BANK_PTR_SFR && regAddr != `PCL_ADDR |=> regRdData == `ZERO_BYTE)
        else $error("unimplemented location did not read zero");

    a_ptr_write_low: assert property (@(posedge core_clk) disable iff (srst)
        doWrite && isBsr |=> bankPtr_r == $past(wrDataSel[`BANK_W-1:0]))
        else $error("bank pointer write lost");

    a_pc_only_ff9: assert property (@(posedge core_clk) disable iff (srst)
        doWrite && !isPcl |=> !pcLowWe)
        else $error("pc low written from another address");

    a_pc_read: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_BANK && accessSel && !opWrite && bankPtr_r == `SFR_BANK && opOffset == `PCL_OFFS
            |=> opRdData == $past(pcLowIn))
        else $error("pc low not read back");

    a_loadb_no_ram: assert property (@(posedge core_clk) disable iff (srst)
        opKind == OP_LOADB |-> !doWrite)
        else $error("load bank touched data memory");
endmodule

// file: test/exec_unit_model.sv
// execution side holder of the program counter low byte
`timescale 1ns/1ps
module exec_unit_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // program counter low byte
    input  wire logic       pcLowWe,
    input  wire logic [7:0] pcLowData,
    output logic      [7:0] pcLowIn
);
    logic [7:0] pcLow_r;
    // ---------------------------------------
    // pc low slot
    // ---------------------------------------
    // no stepping here, so a read back shows exactly what the data path wrote
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pcLow_r <= 8'h3c;
        end else if (pcLowWe) begin
            pcLow_r <= pcLowData;
        end
    end
    assign pcLowIn = pcLow_r;
endmodule

// file: test/banked_data_memory_addressing_tb.sv
// self-checking bench for the banked data memory addressing block
`timescale 1ns/1ps
`include "bank_addr_defines.svh"
module banked_data_memory_addressing_tb;
    import bank_addr_pkg::*;
    typedef struct {
        logic [3:0] bank;
        logic       sel;
        logic [7:0] off;
        logic [7:0] data;
    } row_type;
    // ---------------------------------------
    // signals
    // ---------------------------------------
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    op_type      opKind = OP_NONE;
    logic        opWrite = 1'b0, accessSel = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0]  opOffset = '0, opWrData = '0, regWrData = '0;
    logic [7:0]  pcLowIn;
    logic [7:0]  opRdData, regRdData, pcLowData, opRdS, regRdS;
    logic [11:0] srcAddr = '0, dstAddr = '0, regAddr = '0, addr;
    logic        flagUpdate, pcLowWe, flagS;
    logic [3:0]  bankPointer;
    int          errorCnt = 0, checksDone = 0;
    row_type     rows [6] = '{'{4'h0, 1'b1, 8'h00, 8'ha1}, '{4'h5, 1'b1, 8'h3c, 8'hb2},
                              '{4'hf, 1'b1, 8'h10, 8'hc3}, '{4'ha, 1'b0, 8'h7f, 8'hd4},
                              '{4'h3, 1'b0, 8'h85, 8'he5}, '{4'he, 1'b1, 8'hff, 8'hf6}};

    banked_data_memory_addressing dut (
        .core_clk(core_clk), .srst(srst), .opKind(opKind), .opWrite(opWrite), .accessSel(accessSel),
        .opOffset(opOffset), .srcAddr(srcAddr), .dstAddr(dstAddr), .opWrData(opWrData),
        .opRdData(opRdData), .flagUpdate(flagUpdate), .pcLowIn(pcLowIn), .pcLowWe(pcLowWe),
        .pcLowData(pcLowData), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .bankPointer(bankPointer));
    // a smaller part: banks above 7 are missing
    banked_data_memory_addressing #(.IMPL_BANKS_LAST(4'h7)) dutSmall (
        .core_clk(core_clk), .srst(srst), .opKind(opKind), .opWrite(opWrite), .accessSel(accessSel),
        .opOffset(opOffset), .srcAddr(srcAddr), .dstAddr(dstAddr), .opWrData(opWrData),
        .opRdData(opRdS), .flagUpdate(flagS), .pcLowIn(pcLowIn), .pcLowWe(),
        .pcLowData(), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdS), .bankPointer());
    exec_unit_model pcModel (.core_clk(core_clk), .srst(srst), .pcLowWe(pcLowWe), .pcLowData(pcLowData),
        .pcLowIn(pcLowIn));

    always #2.5 core_clk = ~core_clk;

    // ---------------------------------------
    // helpers
    // ---------------------------------------
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic doOp(input op_type k, input logic w, input logic s, input logic [7:0] o, input logic [7:0] d);
        @(posedge core_clk);
        opKind <= k;
        opWrite <= w;
        accessSel <= s;
        opOffset <= o;
        opWrData <= d;
        @(posedge core_clk);
        opKind <= OP_NONE;
        opWrite <= 1'b0;
        #1;
    endtask

    task automatic regAcc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= w;
        regRead <= ~w;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
    endtask

    function automatic logic [11:0] expAddr(row_type r);
        if (r.sel) return {r.bank, r.off};
        return (r.off < `WIN_SPLIT) ? {4'h0, r.off} : {4'hf, r.off};
    endfunction

    task automatic wrap_up();
        if (errorCnt == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #50us;
        errorCnt++;
        wrap_up();
    end

    // ---------------------------------------
    // sequence
    // ---------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("bankPointer reset", bankPointer, 12'h000);
        // all rows written before any read, so an aliased address shows up as a wrong byte
        foreach (rows[i]) begin
            doOp(OP_LOADB, 1'b0, 1'b0, {4'h0, rows[i].bank}, 8'h00);
            chk("bankPointer", bankPointer, rows[i].bank);
            doOp(OP_BANK, 1'b1, rows[i].sel, rows[i].off, rows[i].data);
            chk("flagUpdate", flagUpdate, 12'h001);
            chk("flagUpdate small", flagS, 12'h001);
        end
        foreach (rows[i]) begin
            addr = expAddr(rows[i]);
            regAcc(1'b0, addr, 8'h00);
            chk("regRdData", regRdData, rows[i].data);
            chk("regRdData small", regRdS, (addr[11:8] > 4'h7) ? 8'h00 : rows[i].data);
            doOp(OP_LOADB, 1'b0, 1'b0, {4'h0, rows[i].bank}, 8'h00);
            doOp(OP_BANK, 1'b0, rows[i].sel, rows[i].off, 8'h00);
            chk("opRdData", opRdData, rows[i].data);
            chk("opRdData small", opRdS, (addr[11:8] > 4'h7) ? 8'h00 : rows[i].data);
        end
        doOp(OP_LOADB, 1'b0, 1'b0, 8'hf7, 8'h00);
        chk("bankPointer nibble", bankPointer, 12'h007);
        regAcc(1'b0, `BANK_PTR_SFR, 8'h00);
        chk("bank pointer read", regRdData, 12'h007);
        regAcc(1'b1, `BANK_PTR_SFR, 8'hab);
        regAcc(1'b0, `BANK_PTR_SFR, 8'h00);
        chk("bank pointer upper", regRdData, 12'h00b);
        @(posedge core_clk);
        srcAddr <= 12'h53c;
        dstAddr <= 12'h2c4;
        doOp(OP_FULL, 1'b0, 1'b1, 8'h00, 8'h00);
        chk("full move data", opRdData, 12'h0b2);
        chk("full move flag", flagUpdate, 12'h001);
        regAcc(1'b0, 12'h2c4, 8'h00);
        chk("full move dest", regRdData, 12'h0b2);
        doOp(OP_LOADB, 1'b0, 1'b0, 8'h0e, 8'h00);
        doOp(OP_BANK, 1'b1, 1'b1, 8'hf9, 8'h66);
        chk("pcLowWe other bank", pcLowWe, 12'h000);
        doOp(OP_LOADB, 1'b0, 1'b0, 8'h0f, 8'h00);
        doOp(OP_BANK, 1'b1, 1'b1, 8'hf9, 8'h55);
        chk("pcLowWe", pcLowWe, 12'h001);
        chk("pcLowData", pcLowData, 12'h055);
        doOp(OP_BANK, 1'b0, 1'b1, 8'hf9, 8'h00);
        chk("pc low read", opRdData, 12'h055);
        // a register write beside an instruction is dropped, while the load bank still lands
        regAcc(1'b1, 12'h200, 8'h11);
        @(posedge core_clk);
        opKind <= OP_LOADB;
        opOffset <= 8'h02;
        regWrite <= 1'b1;
        regWrData <= 8'h77;
        @(posedge core_clk);
        opKind <= OP_NONE;
        regWrite <= 1'b0;
        #1;
        chk("bankPointer beside reg write", bankPointer, 12'h002);
        chk("flag after load bank", flagUpdate, 12'h000);
        regAcc(1'b0, 12'h200, 8'h00);
        chk("reg write beside op", regRdData, 12'h011);
        @(posedge core_clk);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("bankPointer second reset", bankPointer, 12'h000);
        chk("opRdData second reset", opRdData, 12'h000);
        wrap_up();
    end
endmodule
